// *** lsl_ctrl.sv ***
// controller end: buffers words, shifts them out, loads, returns read-back
`default_nettype none
`include "lsl_defs.svh"
module lsl_ctrl
	import lsl_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	lsl_link_if.ctl link,
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [`LSL_WORD_BITS-1:0] wrData,
	input wire logic blankReqN,
	output logic rdValid,
	output logic [`LSL_WORD_BITS-1:0] rdData,
	output logic faultSeen,
	output logic linkOk
);
	typedef struct packed {
		lsl_state_t st;
		logic [3:0] div;
		logic [3:0] bitCnt;
		lsl_word_t tx;
		lsl_word_t sent;
		lsl_word_t cur;
		lsl_word_t rx;
		logic [1:0] doutSync;
		logic sclk;
		logic load;
		logic din;
		logic haveSent;
		logic rdValid;
		lsl_word_t rdData;
		logic faultSeen;
		logic linkOk;
	} lsl_ctl_state_t;
	lsl_ctl_state_t s_q;
	lsl_ctl_state_t s_d;
	logic fValid;
	logic fReady;
	lsl_word_t fData;
	logic tick;
	lsl_fifo #(.WIDTH(`LSL_WORD_BITS), .DEPTH(`LSL_FIFO_DEPTH)) uFifo (
		.mclk(mclk),
		.rstn(rstn),
		.inValid(wrValid),
		.inReady(wrReady),
		.inData(wrData),
		.outValid(fValid),
		.outReady(fReady),
		.outData(fData)
	);
	assign tick = s_q.div == 4'(`LSL_LINK_HALF_CYC - 1);
	assign fReady = s_q.st == LSL_IDLE;
	always_comb
	begin
		s_d = s_q;
		s_d.doutSync = {s_q.doutSync[0], link.serOut};
		s_d.rdValid = 1'b0;
		s_d.div = tick ? 4'h0 : s_q.div + 4'h1;
		case (s_q.st)
			LSL_IDLE:
			begin
				s_d.div = 4'h0;
				if (fValid)
				begin
					s_d.tx = fData;
					s_d.cur = fData;
					s_d.din = fData[7]; // msb first
					s_d.bitCnt = 4'h0;
					s_d.st = LSL_LOW;
				end
			end
			LSL_LOW:
				if (tick)
				begin
					s_d.sclk = 1'b1;
					// driver output before this rise carries the previous word's bit
					s_d.rx = {s_q.rx[6:0], s_q.doutSync[1]};
					s_d.st = LSL_HIGH;
				end
			LSL_HIGH:
				if (tick)
				begin
					s_d.sclk = 1'b0;
					s_d.tx = {s_q.tx[6:0], 1'b0};
					s_d.din = s_q.tx[6];
					s_d.bitCnt = s_q.bitCnt + 4'h1;
					// load only after the full word
					s_d.st = (s_q.bitCnt == 4'h7) ? LSL_LOAD : LSL_LOW;
				end
			LSL_LOAD:
				if (tick)
				begin
					s_d.load = 1'b1;
					s_d.st = LSL_UNLOAD;
				end
			LSL_UNLOAD:
				if (tick)
				begin
					s_d.load = 1'b0;
					s_d.st = LSL_IDLE;
					// read-back belongs to the word before this one
					if (s_q.haveSent)
					begin
						s_d.rdValid = 1'b1;
						s_d.rdData = s_q.rx;
						s_d.linkOk = {s_q.rx[7], s_q.rx[4:0]} == {s_q.sent[7], s_q.sent[4:0]};
						s_d.faultSeen = (s_q.rx[6] == s_q.rx[5]) && s_q.rx[6];
					end
					s_d.haveSent = 1'b1;
					s_d.sent = s_q.cur;
				end
			default:
				s_d.st = LSL_IDLE;
		endcase
	end
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign link.serIn = s_q.din;
	assign link.shiftClk = s_q.sclk;
	assign link.latchLoad = s_q.load;
	assign link.blankN = blankReqN;
	assign rdValid = s_q.rdValid;
	assign rdData = s_q.rdData;
	assign faultSeen = s_q.faultSeen;
	assign linkOk = s_q.linkOk;
endmodule : lsl_ctrl
`default_nettype wire

// *** lsl_defs.svh ***
// constants for the led shift-latch fault driver link
`ifndef LSL_DEFS_SVH
`define LSL_DEFS_SVH
`define LSL_WORD_BITS 8
`define LSL_FLAG_UP_POS 6
`define LSL_FLAG_LO_POS 5
`define LSL_SREG_RST 8'h00
`define LSL_LATCH_RST 8'h00
`define LSL_LINK_HALF_NS 60
`define LSL_CLK_NS 10
`define LSL_LINK_HALF_CYC ((`LSL_LINK_HALF_NS + `LSL_CLK_NS - 1) / `LSL_CLK_NS)
`define LSL_FIFO_DEPTH 16
`endif

// *** lsl_pkg.sv ***
// types shared by both ends of the led driver link
`default_nettype none
`include "lsl_defs.svh"
package lsl_pkg;
	typedef logic [`LSL_WORD_BITS-1:0] lsl_word_t;
	typedef enum logic [2:0]
	{
		LSL_IDLE = 3'h0,
		LSL_LOW = 3'h1,
		LSL_HIGH = 3'h3,
		LSL_LOAD = 3'h2,
		LSL_UNLOAD = 3'h6
	} lsl_state_t;
endpackage : lsl_pkg
`default_nettype wire

// *** lsl_link_if.sv ***
// interface joining controller and led driver pins
`default_nettype none
interface lsl_link_if;
	logic serIn;
	logic shiftClk;
	logic latchLoad;
	logic blankN;
	logic serOut;
	modport drv (input serIn, input shiftClk, input latchLoad, input blankN, output serOut);
	modport ctl (output serIn, output shiftClk, output latchLoad, output blankN, input serOut);
endinterface : lsl_link_if
`default_nettype wire

// *** lsl_fifo.sv ***
// parameterised valid/ready fifo
`default_nettype none
module lsl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_q;
	logic [AW:0] rdPtr_q;
	logic [AW:0] count;
	assign count = wrPtr_q - rdPtr_q;
	assign inReady = count != (AW+1)'(DEPTH);
	assign outValid = count != '0;
	assign outData = mem[rdPtr_q[AW-1:0]];
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end
		else
		begin
			if (inValid && inReady)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (outValid && outReady)
				rdPtr_q <= rdPtr_q + 1'b1;
		end
	end
	// storage without reset keeps it a plain ram
	always_ff @(posedge mclk)
	begin
		if (inValid && inReady)
			mem[wrPtr_q[AW-1:0]] <= inData;
	end
endmodule : lsl_fifo
`default_nettype wire

// *** lsl_driver.sv ***
// led driver end: shift register, load latch, fault insertion, blanking
// Summary of operation
// - each shift-clock rise shifts eight-bit register
// - words travel most significant bit first
// - serial output shows last stage, eight-cycle delay
// - latch takes shifted register data while load is high
// - load fall freezes latch while load low
// - load rise writes fault into bits six, five
// - faults sampled just after load rises
// - any fault on a lit output sets both bits, else clears (model also counts blanked outputs whose latch bit is set)
// - other six register bits stay unchanged
// - per-output fault input models low current
// - after load: bit seven, then flags, then rest
// - controller loads only after eight bits shifted
// - blanking high floats outputs, latch kept
// - blanking never affects shifting or latching
// - reset clears registers, outputs float, output low
// - controller compares returned data bits for integrity
// - controller trusts flags only when they agree
// - controller may test each led alone
`default_nettype none
`include "lsl_defs.svh"
module lsl_driver
	import lsl_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	lsl_link_if.drv link,
	input wire logic [`LSL_WORD_BITS-1:0] openFault,
	output logic [`LSL_WORD_BITS-1:0] ledSinkOut,
	output logic [`LSL_WORD_BITS-1:0] ledSinkOutEnN,
	output logic [`LSL_WORD_BITS-1:0] latchView
);
	typedef struct packed {
		logic [1:0] clkSync;
		logic [1:0] loadSync;
		logic [1:0] blankSync;
		logic [1:0] dinSync;
		logic [7:0] faultSync0;
		logic [7:0] faultSync1;
		logic clkPrev;
		logic loadPrev;
		logic faultPend;
		lsl_word_t sreg;
		lsl_word_t latch;
		logic serOut;
		logic [7:0] outEnN;
	} lsl_drv_state_t;
	lsl_drv_state_t s_q;
	lsl_drv_state_t s_d;
	logic anyFault;
	logic shiftEdge;
	always_comb
	begin
		s_d = s_q;
		s_d.clkSync = {s_q.clkSync[0], link.shiftClk};
		s_d.loadSync = {s_q.loadSync[0], link.latchLoad};
		s_d.blankSync = {s_q.blankSync[0], link.blankN};
		s_d.dinSync = {s_q.dinSync[0], link.serIn};
		s_d.faultSync0 = openFault;
		s_d.faultSync1 = s_q.faultSync0;
		s_d.clkPrev = s_q.clkSync[1];
		s_d.loadPrev = s_q.loadSync[1];
		// blanking is not consulted here at all
		shiftEdge = s_q.clkSync[1] && !s_q.clkPrev;
		if (shiftEdge)
		begin
			s_d.sreg = {s_q.sreg[6:0], s_q.dinSync[1]};
			// new last stage goes out, so bit seven already stands when load rises
			s_d.serOut = s_d.sreg[7];
		end
		// follows shifted data only: inserted fault bits must never light leds
		if (s_q.loadSync[1] && (shiftEdge || !s_q.loadPrev))
			s_d.latch = s_d.sreg;
		// sample one cycle after the rise so the new latch drives the outputs
		s_d.faultPend = s_q.loadSync[1] && !s_q.loadPrev;
		anyFault = |(s_q.faultSync1 & s_q.latch);
		if (s_q.faultPend)
		begin
			s_d.sreg[`LSL_FLAG_UP_POS] = anyFault;
			s_d.sreg[`LSL_FLAG_LO_POS] = anyFault;
		end
		s_d.outEnN = ~s_q.latch | {8{s_q.blankSync[1]}};
	end
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '0;
			s_q.sreg <= `LSL_SREG_RST;
			s_q.latch <= `LSL_LATCH_RST;
			s_q.outEnN <= 8'hFF;
		end
		else
			s_q <= s_d;
	end
	assign link.serOut = s_q.serOut;
	assign ledSinkOut = 8'h00;
	assign ledSinkOutEnN = s_q.outEnN;
	assign latchView = s_q.latch;
endmodule : lsl_driver
`default_nettype wire

// *** lsl_link_chk.sv ***
// assertions on the link pins between controller and driver
`default_nettype none
module lsl_link_chk
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic serIn,
	input wire logic shiftClk,
	input wire logic latchLoad,
	input wire logic blankN,
	input wire logic serOut
);
	logic [3:0] riseCnt_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// rises per word; a short word would leave stale bits in the latch
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			riseCnt_q <= 4'h0;
		else if ($rose(latchLoad))
			riseCnt_q <= 4'h0;
		else if ($rose(shiftClk))
			riseCnt_q <= riseCnt_q + 4'h1;
	property p_rst; $rose(rstn) |-> !serOut && !shiftClk && !latchLoad; endproperty
	a_rst: assert property (p_rst) else $error("link busy after reset");
	property p_outEdge; $changed(serOut) |-> shiftClk; endproperty
	a_outEdge: assert property (p_outEdge) else $error("serial out moved with clock low");
	property p_dinHold; shiftClk |-> $stable(serIn); endproperty
	a_dinHold: assert property (p_dinHold) else $error("serial in moved with clock high");
	property p_clkHigh; $rose(shiftClk) |-> shiftClk [*6] ##1 !shiftClk; endproperty
	a_clkHigh: assert property (p_clkHigh) else $error("clock high phase wrong");
	property p_spacing; $rose(shiftClk) && riseCnt_q < 4'h7 |-> ##12 $rose(shiftClk); endproperty
	a_spacing: assert property (p_spacing) else $error("word bits not back to back");
	property p_loadCnt; $rose(latchLoad) |-> riseCnt_q == 4'h8; endproperty
	a_loadCnt: assert property (p_loadCnt) else $error("load without eight rises");
	property p_loadWidth; $rose(latchLoad) |-> latchLoad [*6] ##1 !latchLoad; endproperty
	a_loadWidth: assert property (p_loadWidth) else $error("load pulse width wrong");
	property p_noClk; latchLoad |-> !shiftClk; endproperty
	a_noClk: assert property (p_noClk) else $error("clock high during load");
	property p_blankQuiet; $changed(blankN) ##1 !shiftClk [*4] |-> $stable(serOut); endproperty
	a_blankQuiet: assert property (p_blankQuiet) else $error("serial out moved on blanking change");
endmodule : lsl_link_chk
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the led driver link
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("wrong value at %0t: %h %h", $time, g, e); end end
module tb_top
	import lsl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, rstn = 0, wrValid = 0, blankReqN = 0, wrReady, rdValid, faultSeen, linkOk;
	lsl_word_t wrData = 8'h00, openFault = 8'h00, rdData, ledSinkOut, ledSinkOutEnN, latchView;
	lsl_word_t sent[$];
	logic flag[$];
	int miscompares = 0, total_checks = 0, rdIdx = 0;
	always #5 mclk = ~mclk;
	lsl_link_if link ();
	lsl_ctrl lsl_ctrl_i (.mclk(mclk), .rstn(rstn), .link(link), .wrValid(wrValid), .wrReady(wrReady),
		.wrData(wrData), .blankReqN(blankReqN), .rdValid(rdValid), .rdData(rdData), .faultSeen(faultSeen),
		.linkOk(linkOk));
	lsl_driver lsl_driver_i (.mclk(mclk), .rstn(rstn), .link(link), .openFault(openFault), .ledSinkOut(ledSinkOut),
		.ledSinkOutEnN(ledSinkOutEnN), .latchView(latchView));
	lsl_link_chk lsl_link_chk_i (.mclk(mclk), .rstn(rstn), .serIn(link.serIn), .shiftClk(link.shiftClk),
		.latchLoad(link.latchLoad), .blankN(link.blankN), .serOut(link.serOut));
	// read-back of a word arrives when the following word has been shifted in and loaded
	always @(negedge mclk)
		if (rdValid === 1'b1 && rdIdx < sent.size())
		begin
			`CHK(rdData, {sent[rdIdx][7], flag[rdIdx], flag[rdIdx], sent[rdIdx][4:0]})
			`CHK(faultSeen, flag[rdIdx])
			`CHK(linkOk, 1'b1)
			rdIdx++;
		end
	task automatic final_report();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	task automatic push(input lsl_word_t w, inout logic refused);
		int n;
		n = 0;
		@(negedge mclk);
		wrValid = 1'b1;
		wrData = w;
		while (wrReady !== 1'b1 && n < 3000)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= 3000)
		begin
			miscompares++;
			final_report();
		end
		refused |= (n > 0);
		@(posedge mclk);
		sent.push_back(w);
		flag.push_back(|(w & openFault));
	endtask : push
	// twenty words overrun the sixteen-word buffer, so refusal is always exercised
	task automatic batch(input lsl_word_t first, input logic onehot);
		logic refused;
		int n;
		refused = 1'b0;
		n = 0;
		push(first, refused);
		for (int i = 1; i < 20; i++)
			push(onehot ? lsl_word_t'(8'h01 << (i % 8)) : lsl_word_t'($urandom), refused);
		@(negedge mclk);
		wrValid = 1'b0;
		`CHK(refused, 1'b1)
		while (rdIdx < sent.size() - 1 && n < 3000)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= 3000)
		begin
			miscompares++;
			final_report();
		end
		`CHK(latchView, sent[sent.size() - 1])
		`CHK(ledSinkOutEnN, blankReqN ? 8'hFF : ~sent[sent.size() - 1])
	endtask : batch
	initial
	begin
		void'($urandom(47));
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		rstn = 1'b1;
		`CHK(ledSinkOutEnN, 8'hFF)
		`CHK(link.serOut, 1'b0)
		`CHK(ledSinkOut, 8'h00)
		batch(8'hFF, 1'b0);
		openFault = 8'h01;
		blankReqN = 1'b1;
		batch(8'hFE, 1'b0);
		openFault = lsl_word_t'($urandom) | 8'h01;
		blankReqN = 1'b0;
		batch(8'h00, 1'b0);
		openFault = lsl_word_t'($urandom);
		batch(8'h80, 1'b1);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
